// File: common/rdrm_defs.vh
// constants for the reference-clock data rate meter
// assumes one system clock; included by bare name
`ifndef RDRM_DEFS_VH
`define RDRM_DEFS_VH

// reference_clock_in_config_reg field positions
`define RDRM_CFG_LOCK_BIT     0
`define RDRM_CFG_FINE_BIT     1
`define RDRM_CFG_RANGE_LO     6
`define RDRM_CFG_RANGE_HI     7
// action_control_reg field position
`define RDRM_ACT_RESTART_BIT  3
// result layout
`define RDRM_RESULT_W         23
`define RDRM_BASE_SHIFT       14
// timing
`define RDRM_CLK_MHZ          200
`define RDRM_MEAS_TIME_MS     80
`define RDRM_MEAS_CYCLES      (`RDRM_MEAS_TIME_MS * 1000 * `RDRM_CLK_MHZ)
// measurement shaping
`define RDRM_AVG_SHIFT        6
`define RDRM_DATA_DIV_LOG2    6
`define RDRM_RESULT_RESET     23'h00_0000

`endif

// File: design/rdrm_sync_edge.v
// two-flop synchroniser with rising and falling edge pulses
// assumes the input is asynchronous to i_clk
`timescale 1ns/1ps
module rdrm_sync_edge (
  input  wire i_clk,    // system clock
  input  wire i_rst_n,  // async reset, active low
  input  wire i_async,  // pin level
  output wire o_level,  // synchronised level
  output wire o_rise,   // one-cycle pulse on rise
  output wire o_fall    // one-cycle pulse on fall
);
  reg meta_q;
  reg sync_q;
  reg prev_q;

  // first flop feeds only the second; edges compare second and third
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign o_level = sync_q;
  assign o_rise  = sync_q & ~prev_q;
  assign o_fall  = ~sync_q & prev_q;
endmodule

// File: design/rdrm_top.v
// reference-clock lock control and fine data rate meter
// assumes register contents arrive as levels on i_clk, the reference
// clock and lock-lost flag arrive as pins, data ticks are on i_clk
`timescale 1ns/1ps
`include "rdrm_defs.vh"
module rdrm_top #(
  parameter MEAS_CYCLES   = `RDRM_MEAS_CYCLES,    // least run time
  parameter AVG_SHIFT     = `RDRM_AVG_SHIFT,      // window averaging
  parameter DATA_DIV_LOG2 = `RDRM_DATA_DIV_LOG2   // bits per data tick
) (
  input  wire        i_clk,                 // 200 MHz system clock
  input  wire        i_rst_n,               // async reset, active low
  input  wire [7:0]  i_reference_clock_in_config,       // reference_clock_in_config_reg value
  input  wire [7:0]  i_action_control,      // action_control_reg value
  input  wire        i_reference_clock_in,  // reference clock pin
  input  wire        i_lock_lost_flag,      // lock lost from cdr core
  input  wire        i_data_tick,           // one per 2^div data bits
  output reg         o_lock_to_ref,         // lock-to-reference active
  output reg  [1:0]  o_ref_div_sel,         // reference divider code
  output reg         o_relock_req,          // relock pulse to cdr core
  output reg         o_clk_hold,            // keep output clock stable
  output reg         o_meas_done,           // completion flag
  output reg         o_meas_busy,           // measurement running
  output reg  [7:0]  o_rate_result_high,    // result bits 22..16
  output reg  [7:0]  o_rate_result_mid,     // result bits 15..8
  output reg  [7:0]  o_rate_result_low      // result bits 7..0
);
  // the reference counter must reach 2^(14+3+avg), which sets its top bit;
  // the data counter is wide enough never to wrap inside a window
  localparam REF_W  = `RDRM_BASE_SHIFT + 3 + AVG_SHIFT + 1;
  localparam DATA_W = 40;
  localparam TMR_W  = 32;
  localparam [TMR_W-1:0] MEAS_LAST = MEAS_CYCLES - 1;

  // idle waits for a restart; arm waits for a reference edge so that
  // the window always opens on an edge and the count is not short by one
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_ARM  = 2'b01;
  localparam [1:0] ST_RUN  = 2'b10;

  wire ref_rise;
  wire lol_level;
  wire lol_rise;

  reg  [1:0]        state_q;
  reg  [1:0]        state_d;
  reg               lock_en_prev_q;
  reg               restart_prev_q;
  reg  [REF_W-1:0]  ref_cnt_q;
  reg  [DATA_W-1:0] data_cnt_q;
  reg  [TMR_W-1:0]  tmr_q;
  reg  [1:0]        range_q;

  // reference clock is sampled as a pin; its rises are counted
  rdrm_sync_edge u_ref_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async (i_reference_clock_in),
    .o_level (),
    .o_rise  (ref_rise),
    .o_fall  ()
  );

  // lock-lost flag synchronised; its rise triggers a relock
  rdrm_sync_edge u_lol_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async (i_lock_lost_flag),
    .o_level (lol_level),
    .o_rise  (lol_rise),
    .o_fall  ()
  );

  // mode decode, both enables together runs neither
  // an unsupported code idles both paths, so nothing is left half-started
  wire lock_bit = i_reference_clock_in_config[`RDRM_CFG_LOCK_BIT];
  wire fine_bit = i_reference_clock_in_config[`RDRM_CFG_FINE_BIT];
  wire lock_mode = lock_bit & ~fine_bit;
  wire fine_mode = fine_bit & ~lock_bit;
  wire [1:0] range =
    i_reference_clock_in_config[`RDRM_CFG_RANGE_HI:`RDRM_CFG_RANGE_LO];
  wire lock_cmd = lock_bit & ~lock_en_prev_q;
  wire restart_bit = i_action_control[`RDRM_ACT_RESTART_BIT];
  wire restart = restart_prev_q & ~restart_bit;

  // window length in reference edges is 2^(14+range+avg)
  wire [REF_W-1:0] ref_target =
    {{(REF_W-1){1'b0}}, 1'b1} << (`RDRM_BASE_SHIFT + range_q + AVG_SHIFT);
  wire win_done = (ref_cnt_q >= ref_target);
  wire tmr_done = (tmr_q >= MEAS_LAST);
  // a restart seen in the finishing cycle throws that window away: the
  // host asked for a fresh measurement, so done must read 0 while it runs
  // and the old result must not be replaced by a discarded one
  wire finish = (state_q == ST_RUN) & win_done & tmr_done & ~restart;

  // data bits seen in the window, scaled back by the averaging
  wire [DATA_W-1:0] bits_scaled =
    (data_cnt_q << DATA_DIV_LOG2) >> AVG_SHIFT;
  wire over = |bits_scaled[DATA_W-1:`RDRM_RESULT_W];
  wire [`RDRM_RESULT_W-1:0] result = over ? {`RDRM_RESULT_W{1'b1}} :
    bits_scaled[`RDRM_RESULT_W-1:0];

  // edge history of the written control bits
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lock_en_prev_q <= 1'b0;
      restart_prev_q <= 1'b0;
    end else begin
      lock_en_prev_q <= lock_bit;
      restart_prev_q <= restart_bit;
    end
  end

  // lock-to-reference control, independent of measurement
  // relock pulse and hold level go to the recovery core outside; hold
  // keeps its clock steady while lock is being regained
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_lock_to_ref <= 1'b0;
      o_ref_div_sel <= 2'b00;
      o_relock_req  <= 1'b0;
      o_clk_hold    <= 1'b0;
    end else begin
      o_lock_to_ref <= lock_mode;
      o_ref_div_sel <= range;
      o_relock_req  <= lock_mode & (lol_rise | lock_cmd);
      o_clk_hold    <= lock_mode & lol_level;
    end
  end

  // measurement sequencer
  // a restart in any busy state starts over from arm
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (fine_mode & restart)
          state_d = ST_ARM;
      end
      ST_ARM: begin
        if (!fine_mode)
          state_d = ST_IDLE;
        else if (ref_rise)
          state_d = ST_RUN;
      end
      ST_RUN: begin
        if (!fine_mode)
          state_d = ST_IDLE;
        else if (restart)
          state_d = ST_ARM;
        else if (finish)
          state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // counters: reference edges, data ticks, least run time
  // they clear outside a run so every window starts from zero; the range
  // is latched as the run starts, so a later write waits for the next run
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q    <= ST_IDLE;
      ref_cnt_q  <= {REF_W{1'b0}};
      data_cnt_q <= {DATA_W{1'b0}};
      tmr_q      <= {TMR_W{1'b0}};
      range_q    <= 2'b00;
    end else begin
      state_q <= state_d;
      if (state_q != ST_RUN) begin
        ref_cnt_q  <= {REF_W{1'b0}};
        data_cnt_q <= {DATA_W{1'b0}};
        tmr_q      <= {TMR_W{1'b0}};
        range_q    <= range;
      end else begin
        if (ref_rise & ~win_done)
          ref_cnt_q <= ref_cnt_q + {{(REF_W-1){1'b0}}, 1'b1};
        if (i_data_tick & ~win_done)
          data_cnt_q <= data_cnt_q + {{(DATA_W-1){1'b0}}, 1'b1};
        if (!tmr_done)
          tmr_q <= tmr_q + {{(TMR_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // done flag and held result bytes; a restart beats a late completion
  // bytes change only on completion, so three reads taken after the flag
  // rises always belong to one measurement
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_meas_done        <= 1'b0;
      o_meas_busy        <= 1'b0;
      o_rate_result_high <= 8'h00;
      o_rate_result_mid  <= 8'h00;
      o_rate_result_low  <= 8'h00;
    end else begin
      o_meas_busy <= (state_d != ST_IDLE);
      if (finish) begin
        o_meas_done        <= 1'b1;
        o_rate_result_high <= {1'b0, result[22:16]};
        o_rate_result_mid  <= result[15:8];
        o_rate_result_low  <= result[7:0];
      end else if (fine_mode & restart) begin
        o_meas_done <= 1'b0;
      end
      // result bytes otherwise keep their value
    end
  end

endmodule

// File: bench/rdrm_props.sv
// checker for the rate meter top ports
// assumes a bind onto rdrm_top and one clock domain
`timescale 1ns/1ps
module rdrm_props #(
  parameter MEAS_CYCLES = 50
) (
  input wire       i_clk, i_rst_n, i_lock_lost_flag,
  input wire [7:0] i_reference_clock_in_config, i_action_control,
  input wire       o_lock_to_ref, o_relock_req, o_clk_hold,
  input wire       o_meas_done, o_meas_busy,
  input wire [1:0] o_ref_div_sel,
  input wire [7:0] o_rate_result_high, o_rate_result_mid,
  input wire [7:0] o_rate_result_low
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire [23:0] res = {o_rate_result_high, o_rate_result_mid,
                     o_rate_result_low};
  // cycles spent busy, for the minimum run time
  reg [31:0] busy_q;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      busy_q <= 32'h0;
    else
      busy_q <= o_meas_busy ? busy_q + 32'h1 : 32'h0;
  end
  // restart: bit 3 falls while only the fine enable is set
  sequence s_restart;
    i_reference_clock_in_config[1:0] == 2'h2 && $past(i_action_control[3]) &&
      !i_action_control[3];
  endsequence
  // lock loss seen while in lock mode
  sequence s_loss;
    $rose(i_lock_lost_flag) && i_reference_clock_in_config[1:0] == 2'h1;
  endsequence
  chk_restart_arm:
    assert property (s_restart |=> !o_meas_done && o_meas_busy)
      else $error("restart did not arm a measurement");
  chk_lock_cmd:
    assert property ($rose(i_reference_clock_in_config[0]) && !i_reference_clock_in_config[1]
      |=> o_relock_req) else $error("lock command gave no relock");
  chk_loss_relock:
    assert property (s_loss |-> ##3 o_relock_req && o_clk_hold)
      else $error("lock loss gave no relock");
  chk_mode_excl:
    assert property (o_lock_to_ref == ($past(i_reference_clock_in_config[1:0])
      == 2'h1)) else $error("lock mode output wrong");
  chk_div_copy:
    assert property (o_ref_div_sel == $past(i_reference_clock_in_config[7:6]))
      else $error("range copy wrong");
  chk_meas_quiet:
    assert property (o_meas_busy |-> !o_relock_req && !o_clk_hold)
      else $error("measurement touched lock outputs");
  chk_done_idle:
    assert property (o_meas_done |-> !o_meas_busy)
      else $error("done while busy");
  chk_result_hold:
    assert property (!$rose(o_meas_done) |-> $stable(res))
      else $error("result changed without completion");
  chk_top_bit:
    assert property (!o_rate_result_high[7])
      else $error("result top bit set");
  chk_min_time:
    assert property ($rose(o_meas_done) |-> busy_q >= MEAS_CYCLES)
      else $error("measurement ended early");
endmodule
bind rdrm_top rdrm_props #(.MEAS_CYCLES(MEAS_CYCLES)) chk_u (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_reference_clock_in_config(i_reference_clock_in_config),
  .i_action_control(i_action_control),
  .i_lock_lost_flag(i_lock_lost_flag), .o_lock_to_ref(o_lock_to_ref),
  .o_ref_div_sel(o_ref_div_sel), .o_relock_req(o_relock_req),
  .o_clk_hold(o_clk_hold), .o_meas_done(o_meas_done),
  .o_meas_busy(o_meas_busy), .o_rate_result_high(o_rate_result_high),
  .o_rate_result_mid(o_rate_result_mid),
  .o_rate_result_low(o_rate_result_low));

// File: bench/rdrm_partner.sv
// reference clock and recovered data tick sources
// assumes i_clk is the 200 MHz system clock of the meter
`timescale 1ns/1ps
module rdrm_partner #(
  parameter REF_HALF_NS = 7  // 71.4 MHz, band scaled for run time
) (
  input  wire i_clk,        // system clock
  output reg  o_ref_clock,  // free running reference
  output reg  o_tick        // one pulse every two cycles
);
  // free running reference, phase unrelated to i_clk
  initial begin
    o_ref_clock = 1'b0;
    #1.3;
    forever #(REF_HALF_NS) o_ref_clock = ~o_ref_clock;
  end
  // data ticks on the falling edge, 64 bits each
  initial o_tick = 1'b0;
  always @(negedge i_clk) o_tick <= ~o_tick;
endmodule

// File: bench/rdrm_top_tb_top.sv
// bench for the rate meter top, driving register levels
// assumes the partner model supplies reference and data ticks
`timescale 1ns/1ps
module rdrm_top_tb_top;
  reg         i_clk, i_rst_n, lost;
  reg  [7:0]  cfg, act;
  reg  [23:0] first;
  wire        ref_clock, tick, lock, req, hold, done, busy;
  wire [1:0]  div;
  wire [7:0]  r_hi, r_mid, r_lo;
  integer     fails, total_checks, i;
  // 200 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  rdrm_top #(.MEAS_CYCLES(50), .AVG_SHIFT(0)) dut_u (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_reference_clock_in_config(cfg), .i_action_control(act),
    .i_reference_clock_in(ref_clock), .i_lock_lost_flag(lost),
    .i_data_tick(tick), .o_lock_to_ref(lock), .o_ref_div_sel(div),
    .o_relock_req(req), .o_clk_hold(hold), .o_meas_done(done),
    .o_meas_busy(busy), .o_rate_result_high(r_hi),
    .o_rate_result_mid(r_mid), .o_rate_result_low(r_lo));
  rdrm_partner src_u (.i_clk(i_clk), .o_ref_clock(ref_clock),
    .o_tick(tick));
  // compare one value and count it
  task check(input [47:0] name, input [23:0] seen, input [23:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("ERROR %0s exp %h seen %h", name, exp, seen);
    end
  endtask
  // config write on a falling edge
  task wr_cfg(input [7:0] v);
    @(negedge i_clk);
    cfg = v;
  endtask
  // restart pulse: bit 3 high for one cycle, then low
  task restart;
    @(negedge i_clk);
    act = 8'h08;
    @(negedge i_clk);
    act = 8'h00;
    @(negedge i_clk);
  endtask
  // read the three result bytes
  task rd_res(output [23:0] v);
    @(negedge i_clk);
    v = {r_hi, r_mid, r_lo};
  endtask
  // counts, verdict and end of run
  task report_and_stop;
    $display("checks %0d errors %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    i_rst_n = 1'b0;
    cfg = 8'h00;
    act = 8'h00;
    lost = 1'b0;
    fails = 0;
    total_checks = 0;
    repeat (3) @(negedge i_clk);
    i_rst_n = 1'b1;
    @(negedge i_clk);
    check("done", done, 1'b0);
    // every range code reaches the divider select
    for (i = 0; i < 4; i = i + 1) begin
      wr_cfg({i[1:0], 6'h00});
      @(negedge i_clk);
      check("div", div, i[1:0]);
    end
    // lock command, loss of lock, refused restarts
    wr_cfg(8'h01);
    @(negedge i_clk);
    check("relock", req, 1'b1);
    lost = 1'b1;
    repeat (5) @(negedge i_clk);
    check("hold", hold, 1'b1);
    restart;
    check("busy", busy, 1'b0);
    wr_cfg(8'h03);
    restart;
    check("both", {lock, busy}, 2'b00);
    // fine mode: restart twice, then wait for completion
    lost = 1'b0;
    wr_cfg(8'h02);
    restart;
    check("arm", {done, busy}, 2'b01);
    repeat (200) @(negedge i_clk);
    restart;
    check("rearm", busy, 1'b1);
    for (i = 0; i < 60000 && done !== 1'b1; i = i + 1)
      @(negedge i_clk);
    check("done", done, 1'b1);
    // the result checks only make sense once a measurement has ended
    if (done === 1'b1) begin
      check("lock", {lock, lost}, 2'b00);
      rd_res(first);
      check("msb", first[23], 1'b0);
      i = first[22:0] > 23'h16_65d4 && first[22:0] < 23'h16_66f8;
      check("rate", i[0], 1'b1);
      // abort a run by clearing the enable: result is kept
      restart;
      wr_cfg(8'h00);
      repeat (2) @(negedge i_clk);
      check("abort", {done, busy}, 2'b00);
      check("kept", {r_hi, r_mid, r_lo}, first);
    end
    report_and_stop;
  end
endmodule
